// *** rcg_consts.svh ***
// Constants of the remote carrier generator
`ifndef RCG_CONSTS_SVH
`define RCG_CONSTS_SVH

// Clock
`define RCG_CLK_PERIOD_NS 10

// Counter and field widths
`define RCG_CAR_W 8
`define RCG_PUL_W 6
`define RCG_PS_W 9
`define RCG_CSEL_W 2
`define RCG_PSEL_W 3

// Carrier clock select codes: SCLK divided by 1, 2, 4, 8
`define RCG_CSEL_DIV1 2'h0
`define RCG_CSEL_DIV2 2'h1
`define RCG_CSEL_DIV4 2'h2
`define RCG_CSEL_DIV8 2'h3

// Pulse clock select: code n taps SCLK/(8 << n), all ones is the carrier
`define RCG_PSEL_CARRIER 3'h7
`define RCG_PSEL_BASE_BITS 3

// Reset values
`define RCG_CAR_CNT_RST 8'h00
`define RCG_PUL_CNT_RST 6'h00
`define RCG_PS_RST 9'h000

`endif

// *** rcg_pkg.sv ***
// Types of the remote carrier generator
`default_nettype none

package rcg_pkg;

    // Phase of a two-phase counter, one bit so the code is Gray
    typedef enum logic {
        RCG_PH_HIGH = 1'b0,
        RCG_PH_LOW = 1'b1
    } rcg_phase_t;

    // Configuration of the remote mode register and the length registers
    typedef struct packed {
        logic carrier_enable;
        logic [1:0] carrier_clk_sel;
        logic [7:0] carrier_high_count;
        logic [7:0] carrier_low_count;
        logic pulse_enable;
        logic [2:0] pulse_clk_sel;
        logic [5:0] pulse_high_count;
        logic [5:0] pulse_low_count;
    } rcg_cfg_t;

    // Software access strobes towards the flag and the data bit
    typedef struct packed {
        logic data_wr;
        logic data_wdata;
        logic flag_wr_zero;
        logic irq_ack;
    } rcg_sw_t;

endpackage

`default_nettype wire

// *** rcg_top.sv ***
// Remote carrier generator: carrier counter, pulse counter and remote output pin
// Function
// - Pin built from carrier and data bit.
// - Carrier enable switches carrier generation independently.
// - Data bit loads buffer on match, writable.
// - All four carrier/update combinations supported.
// - Carrier high lasts high count ticks.
// - Carrier low lasts low count ticks.
// - Pulse high lasts pulse high count ticks.
// - Pulse low lasts pulse low count ticks.
// - Match sets flag and requests interrupt.
// - Pulse counter and interrupt need pulse enable.
// - Flag readable without interrupt service.
// - Flag clears on service, disable, zero write.
// - Carrier off: pin shows data bit only.
// - Carrier taps include SCLK/2 and SCLK/8.
// - Carrier on ANDs; off stops counter.
// - Carrier clock SCLK/1,2,4,8 by 2-bit select.
// - Pulse clock SCLK/8..512 or carrier wave.
`timescale 1ns/100ps
`default_nettype none
`include "rcg_consts.svh"

module rcg_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Configuration from the register bank
    input wire rcg_pkg::rcg_cfg_t cfg_i,
    // Output buffer bit
    input wire logic out_buffer_bit_i,
    // Software strobes
    input wire rcg_pkg::rcg_sw_t sw_i,
    // Remote output pin
    output logic remote_out_pin_o,
    // Status
    output logic out_data_bit_o,
    output logic pulse_match_flag_o,
    output logic irq_o,
    output logic carrier_wave_o,
    output logic [`RCG_CAR_W-1:0] carrier_count_o,
    output logic [`RCG_PUL_W-1:0] pulse_count_o
);
    import rcg_pkg::*;

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------

    logic [`RCG_PS_W-1:0] ps_r;
    logic [`RCG_PS_W-1:0] ps_nxt;

    // Free-running so every tap stays in phase with the others
    assign ps_nxt = ps_r + `RCG_PS_W'(1);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ps_r <= `RCG_PS_RST;
        end else begin
            ps_r <= ps_nxt;
        end
    end

    // Tap n ticks once every 2**(n+1) cycles
    logic [`RCG_PS_W-1:0] tap;
    genvar gi;
    generate
        for (gi = 0; gi < `RCG_PS_W; gi = gi + 1) begin : g_tap
            assign tap[gi] = &ps_r[gi:0];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Carrier counter
    // ----------------------------------------------------------------

    rcg_phase_t c_ph_r;
    rcg_phase_t c_ph_nxt;
    logic [`RCG_CAR_W-1:0] c_cnt_r;
    logic [`RCG_CAR_W-1:0] c_cnt_nxt;
    logic [`RCG_CAR_W-1:0] c_cnt_inc;
    logic [`RCG_CAR_W-1:0] c_len;
    logic c_tick;
    logic c_end;
    logic c_rise;

    // Carrier counting clock choice
    assign c_tick = (cfg_i.carrier_clk_sel == `RCG_CSEL_DIV1) ? 1'b1 :
                    (cfg_i.carrier_clk_sel == `RCG_CSEL_DIV2) ? tap[0] :
                    (cfg_i.carrier_clk_sel == `RCG_CSEL_DIV4) ? tap[1] :
                    tap[2];

    // Length of the phase in progress
    assign c_len = (c_ph_r == RCG_PH_HIGH) ? cfg_i.carrier_high_count :
                   cfg_i.carrier_low_count;
    assign c_cnt_inc = c_cnt_r + `RCG_CAR_W'(1);
    // A zero length would only match once the count wraps, so it ends the phase on each tick
    assign c_end = c_tick && ((c_cnt_inc == c_len) || (c_len == '0));
    // Start of a high phase clocks the pulse counter in carrier mode
    assign c_rise = cfg_i.carrier_enable && c_end && (c_ph_r == RCG_PH_LOW);

    // Next carrier state; disabled carrier is parked at the start of high
    always_comb begin
        c_cnt_nxt = c_cnt_r;
        c_ph_nxt = c_ph_r;
        if (!cfg_i.carrier_enable) begin
            c_cnt_nxt = `RCG_CAR_CNT_RST;
            c_ph_nxt = RCG_PH_HIGH;
        end else if (c_end) begin
            c_cnt_nxt = `RCG_CAR_CNT_RST;
            c_ph_nxt = (c_ph_r == RCG_PH_HIGH) ? RCG_PH_LOW : RCG_PH_HIGH;
        end else if (c_tick) begin
            c_cnt_nxt = c_cnt_inc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            c_cnt_r <= `RCG_CAR_CNT_RST;
            c_ph_r <= RCG_PH_HIGH;
        end else begin
            c_cnt_r <= c_cnt_nxt;
            c_ph_r <= c_ph_nxt;
        end
    end

    logic carrier_wave;
    logic carrier_wave_r;
    assign carrier_wave = (c_ph_r == RCG_PH_HIGH);

    // Registered twin of the phase, so the wave output leaves a flip-flop
    // while the pin logic keeps the decoded phase with no extra lag
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            carrier_wave_r <= 1'b1;
        end else begin
            carrier_wave_r <= (c_ph_nxt == RCG_PH_HIGH);
        end
    end

    // ----------------------------------------------------------------
    // Pulse counter
    // ----------------------------------------------------------------

    rcg_phase_t p_ph_r;
    rcg_phase_t p_ph_nxt;
    logic [`RCG_PUL_W-1:0] p_cnt_r;
    logic [`RCG_PUL_W-1:0] p_cnt_nxt;
    logic [`RCG_PUL_W-1:0] p_cnt_inc;
    logic [`RCG_PUL_W-1:0] p_len;
    logic [`RCG_PS_W-1:0] p_div_tap;
    logic p_tick;
    logic p_match;

    // Code n picks tap n+2, i.e. SCLK/8 up to SCLK/512
    assign p_div_tap = tap >> cfg_i.pulse_clk_sel;
    assign p_tick = (cfg_i.pulse_clk_sel == `RCG_PSEL_CARRIER) ? c_rise :
                    p_div_tap[`RCG_PSEL_BASE_BITS-1];

    assign p_len = (p_ph_r == RCG_PH_HIGH) ? cfg_i.pulse_high_count :
                   cfg_i.pulse_low_count;
    assign p_cnt_inc = p_cnt_r + `RCG_PUL_W'(1);
    // Only a running counter can match
    assign p_match = cfg_i.pulse_enable && p_tick &&
                     ((p_cnt_inc == p_len) || (p_len == '0));

    // Next pulse state; disabled counter waits at zero
    always_comb begin
        p_cnt_nxt = p_cnt_r;
        p_ph_nxt = p_ph_r;
        if (!cfg_i.pulse_enable) begin
            p_cnt_nxt = `RCG_PUL_CNT_RST;
            p_ph_nxt = RCG_PH_HIGH;
        end else if (p_match) begin
            p_cnt_nxt = `RCG_PUL_CNT_RST;
            p_ph_nxt = (p_ph_r == RCG_PH_HIGH) ? RCG_PH_LOW : RCG_PH_HIGH;
        end else if (p_tick) begin
            p_cnt_nxt = p_cnt_inc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            p_cnt_r <= `RCG_PUL_CNT_RST;
            p_ph_r <= RCG_PH_HIGH;
        end else begin
            p_cnt_r <= p_cnt_nxt;
            p_ph_r <= p_ph_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Data bit, flag and interrupt request
    // ----------------------------------------------------------------

    logic out_data_r;
    logic out_data_nxt;
    logic flag_r;
    logic flag_nxt;
    logic flag_clr;
    logic irq_r;
    logic pin_r;
    logic pin_nxt;

    // Match load wins over a write in the same cycle
    assign out_data_nxt = p_match ? out_buffer_bit_i :
                          sw_i.data_wr ? sw_i.data_wdata :
                          out_data_r;
    // A match in the cycle of a clear is kept
    assign flag_clr = sw_i.irq_ack || sw_i.flag_wr_zero || !cfg_i.pulse_enable;
    assign flag_nxt = p_match || (flag_r && !flag_clr);
    // Carrier gates the data bit only while it is enabled
    assign pin_nxt = cfg_i.carrier_enable ? (carrier_wave && out_data_r) :
                     out_data_r;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            out_data_r <= 1'b0;
            flag_r <= 1'b0;
            irq_r <= 1'b0;
            pin_r <= 1'b0;
        end else begin
            out_data_r <= out_data_nxt;
            flag_r <= flag_nxt;
            irq_r <= p_match;
            pin_r <= pin_nxt;
        end
    end

    // Status and pin straight from flip-flops
    assign remote_out_pin_o = pin_r;
    assign out_data_bit_o = out_data_r;
    assign pulse_match_flag_o = flag_r;
    assign irq_o = irq_r;
    assign carrier_wave_o = carrier_wave_r;
    assign carrier_count_o = c_cnt_r;
    assign pulse_count_o = p_cnt_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_pin_data_only: assert property (
        !cfg_i.carrier_enable |=> remote_out_pin_o == $past(out_data_r))
        else $error("pin differs from data bit with carrier off");

    a_pin_and_carrier: assert property (
        cfg_i.carrier_enable |=> remote_out_pin_o == $past(carrier_wave && out_data_r))
        else $error("pin is not carrier AND data");

    a_carrier_parked: assert property (
        !cfg_i.carrier_enable |=> carrier_count_o == '0 && carrier_wave_o)
        else $error("carrier counter runs while disabled");

    a_carrier_phase_end: assert property (
        cfg_i.carrier_enable && c_tick && c_cnt_inc == c_len
        |=> carrier_count_o == '0 && carrier_wave_o != $past(carrier_wave))
        else $error("carrier phase did not end at its length");

    a_carrier_div8: assert property (
        cfg_i.carrier_enable && cfg_i.carrier_clk_sel == `RCG_CSEL_DIV8 && c_tick
        |-> ps_r[2:0] == 3'h7
        ##1 (!c_tick || cfg_i.carrier_clk_sel != `RCG_CSEL_DIV8) [*7])
        else $error("carrier SCLK/8 tap ticks too often");

    a_carrier_div2: assert property (
        cfg_i.carrier_clk_sel == `RCG_CSEL_DIV2 && c_tick
        |=> !c_tick || cfg_i.carrier_clk_sel != `RCG_CSEL_DIV2)
        else $error("carrier SCLK/2 tap ticks too often");

    a_pulse_phase_end: assert property (
        p_match |=> pulse_count_o == '0 && p_ph_r != $past(p_ph_r))
        else $error("pulse phase did not restart on match");

    a_flag_on_match: assert property (
        p_match |=> pulse_match_flag_o && irq_o && out_data_bit_o == $past(out_buffer_bit_i))
        else $error("match did not set flag, request or load data");

    a_flag_cleared: assert property (
        pulse_match_flag_o && !p_match && (sw_i.irq_ack || sw_i.flag_wr_zero)
        |=> !pulse_match_flag_o)
        else $error("flag survived a clear");

    a_irq_needs_enable: assert property (
        !cfg_i.pulse_enable |=> !irq_o && !pulse_match_flag_o && pulse_count_o == '0)
        else $error("pulse logic active while disabled");

    a_data_hold: assert property (
        !cfg_i.pulse_enable && !sw_i.data_wr |=> $stable(out_data_bit_o))
        else $error("data bit changed without write");

    a_pulse_div_tap: assert property (
        cfg_i.pulse_enable && cfg_i.pulse_clk_sel == 3'h0 && p_tick
        |-> ps_r[2:0] == 3'h7
        ##1 (!p_tick || cfg_i.pulse_clk_sel != 3'h0) [*7])
        else $error("pulse SCLK/8 tap out of phase");

    a_pulse_on_carrier: assert property (
        cfg_i.pulse_clk_sel == `RCG_PSEL_CARRIER && p_tick
        |=> carrier_wave_o && carrier_count_o == '0)
        else $error("carrier-clocked pulse tick off the carrier rise");

endmodule
`default_nettype wire

// *** rcg_emitter_model.sv ***
// Behavioural infrared emitter hanging on the remote output pin
`timescale 1ns/100ps
`default_nettype none

module rcg_emitter_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Pin from the generator
    input wire logic led_i,
    // Lit time in cycles
    output logic [15:0] lit_o
);
    // Lights only while the pin is high; wraps after 65536 lit cycles
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lit_o <= 16'h0000;
        end else if (led_i) begin
            lit_o <= lit_o + 16'h0001;
        end
    end
endmodule

`default_nettype wire

// *** rcg_top_tb.sv ***
// Self-checking bench of the remote carrier generator
`timescale 1ns/100ps
`default_nettype none

module rcg_top_tb;
    import rcg_pkg::*;
    typedef struct {int gap; logic dat;} rcg_note_t;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    rcg_cfg_t cfg = '0;
    rcg_sw_t sw = '0;
    logic buf_b = 1'b0;
    logic pin, dat, flag, irq, wave;
    logic [7:0] ccnt;
    logic [5:0] pcnt;
    logic [15:0] lit;
    logic pv_ok = 1'b0;
    logic pv_car_on, pv_w, pv_d;
    int n_mismatch = 0;
    int check_count = 0;
    int gap = 0;
    int l0;
    rcg_note_t q[$];
    rcg_note_t nt;
    rcg_note_t ne;

    rcg_top rcg_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg),
        .out_buffer_bit_i(buf_b), .sw_i(sw), .remote_out_pin_o(pin),
        .out_data_bit_o(dat), .pulse_match_flag_o(flag), .irq_o(irq),
        .carrier_wave_o(wave), .carrier_count_o(ccnt), .pulse_count_o(pcnt));
    rcg_emitter_model rcg_emitter_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .led_i(pin), .lit_o(lit));

    // 100 MHz clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Verdict and compares
    // ----------------------------------------
    task results;
        if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk_b(input logic g, input logic e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t bit %b expected %b", $time, g, e);
        end
    endtask
    task automatic chk_i(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %0t count %0d expected %0d", $time, g, e);
        end
    endtask
    // Inputs move 1 ns after the edge, away from sampling
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wait_irq;
        int k = 0;
        step(1);
        while (irq !== 1'b1 && k < 3000) begin
            step(1);
            k++;
        end
        if (k >= 3000) chk_b(1'b1, 1'b0);
    endtask

    // Monitor: pin lags its sources by one cycle; each irq takes a note
    always @(negedge clk_i) begin
        gap++;
        if (pv_ok) chk_b(pin, pv_car_on ? pv_w & pv_d : pv_d);
        pv_ok = rst_n_i;
        pv_car_on = cfg.carrier_enable;
        pv_w = wave;
        pv_d = dat;
        if (irq === 1'b1) begin
            if (q.size() == 0) begin
                chk_b(1'b1, 1'b0);
            end else begin
                nt = q.pop_front();
                chk_b(dat, nt.dat);
                if (nt.gap > 0) chk_i(gap, nt.gap);
                chk_b(flag, 1'b1);
            end
            gap = 0;
        end
    end

    // ----------------------------------------
    // Scenario tasks
    // ----------------------------------------
    // Direct writes, random values
    task automatic wr(input int n);
        logic d;
        repeat (n) begin
            d = 1'($urandom % 2);
            sw.data_wr = 1'b1;
            sw.data_wdata = d;
            step(1);
            chk_b(dat, d);
        end
        // Strobe held across back-to-back writes, dropped once at the end
        sw.data_wr = 1'b0;
    endtask
    // Measure one whole high and low phase of the carrier
    task automatic car(input logic [1:0] sel, input int d);
        int h, l, hi, lo, k;
        h = 1 + $urandom % 6;
        l = 1 + $urandom % 6;
        hi = 0;
        lo = 0;
        k = 0;
        // Park first: a length below the running count would force a wrap
        cfg.carrier_enable = 1'b0;
        step(1);
        cfg.carrier_enable = 1'b1;
        cfg.carrier_clk_sel = sel;
        cfg.carrier_high_count = h[7:0];
        cfg.carrier_low_count = l[7:0];
        while (wave !== 1'b0 && k < 200) begin @(negedge clk_i); k++; end
        while (wave !== 1'b1 && k < 200) begin @(negedge clk_i); k++; end
        while (wave === 1'b1 && k < 300) begin @(negedge clk_i); hi++; k++; end
        while (wave === 1'b0 && k < 400) begin @(negedge clk_i); lo++; k++; end
        chk_i(hi, h * d);
        chk_i(lo, l * d);
        step(1);
    endtask
    // Pulse run: the first match closes a high phase of unknown start
    task automatic pul(input logic [2:0] code, input int f, input int n);
        int h, l;
        rcg_note_t e;
        h = 1 + $urandom % 4;
        l = 1 + $urandom % 4;
        cfg.pulse_clk_sel = code;
        cfg.pulse_high_count = h[5:0];
        cfg.pulse_low_count = l[5:0];
        cfg.pulse_enable = 1'b1;
        for (int i = 0; i < n; i++) begin
            buf_b = 1'($urandom % 2);
            e.dat = buf_b;
            e.gap = i == 0 ? 0 : ((i % 2) ? l : h) * f;
            q.push_back(e);
            wait_irq();
        end
    endtask
    // Software clear of the flag, strobe chosen by k
    task automatic clr(input int k);
        sw.flag_wr_zero = k == 0;
        sw.irq_ack = k == 1;
        step(1);
        sw = '0;
        chk_b(flag, 1'b0);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(42));
        step(8);
        rst_n_i = 1'b1;
        step(1);
        chk_b(ccnt === 8'h00 && pcnt === 6'h00 && wave === 1'b1, 1'b1);
        wr(6);
        step(1);
        sw.data_wr = 1'b1;
        sw.data_wdata = 1'b1;
        step(1);
        sw.data_wr = 1'b0;
        step(2);
        l0 = int'(lit);
        step(10);
        chk_i(int'(lit) - l0, 10);
        car(2'h0, 1);
        car(2'h1, 2);
        car(2'h2, 4);
        car(2'h3, 8);
        wr(6);
        pul(3'h0, 8, 4);
        cfg.carrier_enable = 1'b0;
        pul(3'h1, 16, 4);
        cfg.carrier_enable = 1'b1;
        cfg.carrier_clk_sel = 2'h0;
        cfg.carrier_high_count = 8'h02;
        cfg.carrier_low_count = 8'h01;
        pul(3'h7, 3, 4);
        chk_b(flag, 1'b1);
        clr(0);
        ne.gap = 0;
        ne.dat = buf_b;
        q.push_back(ne);
        q.push_back(ne);
        wait_irq();
        clr(1);
        wait_irq();
        cfg.pulse_enable = 1'b0;
        step(1);
        chk_b(flag === 1'b0 && pcnt === 6'h00, 1'b1);
        step(200);
        results();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #500000;
        n_mismatch++;
        results();
    end
endmodule

`default_nettype wire
